// *** include/optical_diag_consts.svh ***
`ifndef OPTICAL_DIAG_CONSTS_SVH
`define OPTICAL_DIAG_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_EXT_CONFIG 8'h0B
`define ADDR_RESULT_LOW 8'h0C
`define ADDR_RESULT_HIGH 8'h0D
`define ADDR_EXPOSURE_LOW 8'h0E
`define ADDR_EXPOSURE_HIGH 8'h0F
`define ADDR_PERIOD_LOW 8'h10
`define ADDR_PERIOD_HIGH 8'h11
`define ADDR_MOVEMENT_ZERO 8'h12
`define ADDR_SNAPSHOT_PORT 8'h13
`define ADDR_PROG_MEM_CMD 8'h14
`define ADDR_FP_MAX_LOW 8'h19
`define ADDR_FP_MAX_HIGH 8'h1A
`define ADDR_FP_MIN_LOW 8'h1B
`define ADDR_FP_MIN_HIGH 8'h1C
`define ADDR_EXP_MAX_LOW 8'h1D
`define ADDR_EXP_MAX_HIGH 8'h1E

// ****************************************************************
// Field positions of the extended configuration register
// ****************************************************************
`define EXT_BUSY_BIT 7
`define EXT_ONE_BIT 3
`define EXT_PULLUP_OFF_BIT 2
`define EXT_GAIN_LOOP_DISABLE_BIT 1
`define EXT_MANUAL_RATE_BIT 0

// ****************************************************************
// Reset values, command codes and result words
// ****************************************************************
`define EXT_CONFIG_RST 8'h08
`define EXPOSURE_RST 16'h0085
`define FP_MAX_RST 16'h6590
`define FP_MIN_RST 16'h0E7E
`define EXP_MAX_RST 16'h4E20
`define RESULT_RST 16'h0000
`define CAPTURE_CMD 8'h83
`define CRC_START_CMD 8'hA1
`define SELFTEST_PASS_WORD 16'hA9D5
`define CRC_PASS_WORD 16'hBEEF

// ****************************************************************
// Capture size, exposure loop thresholds and timing
// ****************************************************************
`define CAPTURE_PIXELS 11'd1536
`define EXP_STEP_SHIFT 4
`define AVG_LOW_LIMIT 8'h40
`define AVG_HIGH_LIMIT 8'hB0
`define PEAK_HIGH_LIMIT 8'hF0
`define BUSY_FRAMES 2'd2
`define CLK_FREQ_MHZ 20
`define CRC_TIME_US 7000

`endif

// *** include/optical_diag_pkg.sv ***
package optical_diag_pkg;

	// Register port request from the serial front end.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Per-frame pixel stream and statistics from the array.
	typedef struct packed {
		logic sof;
		logic valid;
		logic [7:0] data;
		logic [7:0] avg;
		logic [7:0] peak;
	} pix_in_t;

	// Capture sequence, Gray coded along arm, fill, ready.
	typedef enum logic [1:0] {
		CAP_IDLE = 2'b00,
		CAP_ARM = 2'b01,
		CAP_FILL = 2'b11,
		CAP_READY = 2'b10
	} cap_state_t;

endpackage : optical_diag_pkg

// *** verilog/optical_sensor_diag_capture_regs.sv ***
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "optical_diag_consts.svh"

// How it works
// - Result word shows latest test outcome.
// - Result bytes readable in either order.
// - Pass words are A9D5 and BEEF.
// - Self test follows reset; settings lost.
// - Command code starts program memory CRC.
// - Exposure is 16-bit, upper byte first.
// - Automatic mode checks exposure every frame unless navigation is halted.
// - Each step moves exposure by one sixteenth, at least one count.
// - Exposure capped at bound; fixed when disabled.
// - Current frame period readable, upper first.
// - Any write zeroes motion counters only.
// - Capture code stores 1536 pixels.
// - Capture halts navigation until hardware reset.
// - Each snapshot read returns next pixel.
// - Register and burst reads share pointer.
// - Snapshot read returns zero until ready.
// - Snapshot port never echoes written value.
// - CRC waits 7ms plus frame; halts navigation.
// - Gain loop disable applies exposure bound.
module optical_sensor_diag_capture_regs
	import optical_diag_pkg::*;
#(
	parameter int unsigned CRC_CYCLES = `CRC_TIME_US * `CLK_FREQ_MHZ
) (
	input wire logic i_clk, // 20 MHz system clock.
	input wire logic i_resetn, // Asynchronous reset, active low.
	input wire logic i_ce, // Clock enable; all state holds while low.
	input wire reg_req_t i_req, // Register port request.
	output logic [7:0] o_rd_data, // Read data, valid the cycle after a read.
	input wire pix_in_t i_pix, // Pixel stream and frame statistics.
	input wire logic i_burst_rd, // Pixel burst read strobe.
	output logic [7:0] o_burst_data, // Burst pixel, valid the cycle after a strobe.
	input wire logic i_selftest_done, // Self test finished pulse.
	input wire logic i_selftest_ok, // Self test outcome, with done.
	input wire logic [15:0] i_selftest_value, // Self test failure signature.
	input wire logic [15:0] i_crc_value, // Program memory CRC result.
	input wire logic i_crc_ok, // Program memory CRC matched.
	output logic o_crc_start, // One-cycle start of the CRC engine.
	output logic o_crc_busy, // CRC test in progress.
	output logic o_motion_clear, // One-cycle clear of motion counters.
	output logic o_nav_halt, // Navigation halted.
	output logic o_firmware_lost, // Program memory overwritten by capture.
	output logic o_pullup_off, // Serial pull-up disable.
	output logic o_manual_rate, // Manual frame rate selected.
	output logic o_frame_tick // One-cycle pulse at each frame end.
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0] ext_cfg_q;
	logic [15:0] fp_max_shadow_q;
	logic [15:0] fp_min_shadow_q;
	logic [15:0] exp_max_shadow_q;
	logic [15:0] fp_max_q;
	logic [15:0] fp_min_q;
	logic [15:0] exp_max_q;
	logic [1:0] busy_cnt_q;
	logic [15:0] exposure_q;
	logic [15:0] exposure_d;
	logic [15:0] period_q;
	logic [15:0] period_d;
	logic [15:0] frame_cnt_q;
	logic frame_end;
	logic [15:0] result_q;
	logic [7:0] exp_low_snap_q;
	logic [7:0] period_low_snap_q;
	logic [17:0] crc_cnt_q;
	logic crc_wait_frame_q;
	cap_state_t cap_state_q;
	logic [10:0] fill_cnt_q;
	logic [10:0] ptr_q;
	logic [7:0] capture_mem [0:1535];
	logic [7:0] pixel_at_ptr;
	logic wr_hit;
	logic rd_hit;
	logic snap_rd;
	logic gain_loop_disable;
	logic manual_rate_select;
	logic [16:0] exp_up;
	logic [15:0] exp_step;
	logic [16:0] auto_period;
	logic [7:0] rd_value;

	assign wr_hit = i_ce && i_req.wr;
	assign rd_hit = i_ce && i_req.rd;
	assign snap_rd = rd_hit && (i_req.addr == `ADDR_SNAPSHOT_PORT);
	assign gain_loop_disable = ext_cfg_q[`EXT_GAIN_LOOP_DISABLE_BIT];
	assign manual_rate_select = ext_cfg_q[`EXT_MANUAL_RATE_BIT];
	assign frame_end = i_ce && (frame_cnt_q >= period_q - 16'h0001);

	// ****************************************************************
	// Configuration and bound registers
	// ****************************************************************

	// Bound writes land in shadows and only take effect on the period
	// upper write, so a half-written set never reaches the frame logic.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ext_cfg_q <= `EXT_CONFIG_RST;
			fp_max_shadow_q <= `FP_MAX_RST;
			fp_min_shadow_q <= `FP_MIN_RST;
			exp_max_shadow_q <= `EXP_MAX_RST;
			fp_max_q <= `FP_MAX_RST;
			fp_min_q <= `FP_MIN_RST;
			exp_max_q <= `EXP_MAX_RST;
		end else if (wr_hit) begin
			unique case (i_req.addr)
				`ADDR_EXT_CONFIG: begin
					ext_cfg_q <= {1'b0, 3'b000, 1'b1, i_req.wdata[2:0]};
				end
				`ADDR_FP_MAX_LOW: fp_max_shadow_q[7:0] <= i_req.wdata;
				`ADDR_FP_MIN_LOW: fp_min_shadow_q[7:0] <= i_req.wdata;
				`ADDR_FP_MIN_HIGH: fp_min_shadow_q[15:8] <= i_req.wdata;
				`ADDR_EXP_MAX_LOW: exp_max_shadow_q[7:0] <= i_req.wdata;
				`ADDR_EXP_MAX_HIGH: exp_max_shadow_q[15:8] <= i_req.wdata;
				`ADDR_FP_MAX_HIGH: begin
					fp_max_shadow_q[15:8] <= i_req.wdata;
					fp_max_q <= {i_req.wdata, fp_max_shadow_q[7:0]};
					fp_min_q <= fp_min_shadow_q;
					exp_max_q <= exp_max_shadow_q;
				end
				default: begin
				end
			endcase
		end
	end

	// Busy covers the two frames the new bounds need to settle.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_cnt_q <= 2'd0;
		end else if (wr_hit && i_req.addr == `ADDR_FP_MAX_HIGH) begin
			busy_cnt_q <= `BUSY_FRAMES;
		end else if (frame_end && busy_cnt_q != 2'd0) begin
			busy_cnt_q <= busy_cnt_q - 2'd1;
		end
	end

	// ****************************************************************
	// Frame timer and current period
	// ****************************************************************

	// In automatic mode the period follows exposure plus the minimum
	// bound, limited by the maximum bound; in manual mode it is the bound.
	always_comb begin
		auto_period = {1'b0, fp_min_q} + {1'b0, exposure_q};
		if (manual_rate_select || auto_period > {1'b0, fp_max_q}) begin
			period_d = fp_max_q;
		end else begin
			period_d = auto_period[15:0];
		end
		if (period_d == 16'h0000) begin
			period_d = 16'h0001;
		end
	end

	// The period register is reloaded only at frame ends, so the value
	// read back is the one the running frame really uses.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			frame_cnt_q <= 16'h0000;
			period_q <= `FP_MAX_RST;
		end else if (frame_end) begin
			frame_cnt_q <= 16'h0000;
			period_q <= period_d;
		end else if (i_ce) begin
			frame_cnt_q <= frame_cnt_q + 16'h0001;
		end
	end

	// ****************************************************************
	// Automatic exposure loop
	// ****************************************************************

	// One sixteenth step, never less than one count so that small
	// exposures can still climb.
	always_comb begin
		exp_step = exposure_q >> `EXP_STEP_SHIFT;
		if (exp_step == 16'h0000) begin
			exp_step = 16'h0001;
		end
		exp_up = {1'b0, exposure_q} + {1'b0, exp_step};
		exposure_d = exposure_q;
		if (gain_loop_disable) begin
			exposure_d = exp_max_q;
		end else if (i_pix.peak > `PEAK_HIGH_LIMIT || i_pix.avg > `AVG_HIGH_LIMIT) begin
			if (exposure_q > exp_step) begin
				exposure_d = exposure_q - exp_step;
			end
		end else if (i_pix.avg < `AVG_LOW_LIMIT) begin
			exposure_d = exp_up[15:0];
		end
		if ({1'b0, exposure_d} > {1'b0, exp_max_q} || exp_up[16] && !gain_loop_disable &&
			i_pix.avg < `AVG_LOW_LIMIT) begin
			exposure_d = exp_max_q;
		end
	end

	// The loop is checked once per frame and frozen while navigation
	// is halted, since no fresh statistics arrive then.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			exposure_q <= `EXPOSURE_RST;
		end else if (frame_end && !o_nav_halt) begin
			exposure_q <= exposure_d;
		end
	end

	// ****************************************************************
	// Test result word and CRC sequence
	// ****************************************************************

	// The CRC runs for its fixed time, then waits for one more frame
	// end before the result is trusted.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			crc_cnt_q <= 18'd0;
			crc_wait_frame_q <= 1'b0;
			o_crc_busy <= 1'b0;
			o_crc_start <= 1'b0;
		end else if (i_ce) begin
			o_crc_start <= 1'b0;
			if (wr_hit && i_req.addr == `ADDR_PROG_MEM_CMD &&
				i_req.wdata == `CRC_START_CMD && !o_crc_busy) begin
				crc_cnt_q <= 18'(CRC_CYCLES);
				o_crc_busy <= 1'b1;
				o_crc_start <= 1'b1;
			end else if (crc_cnt_q != 18'd0) begin
				crc_cnt_q <= crc_cnt_q - 18'd1;
				crc_wait_frame_q <= (crc_cnt_q == 18'd1);
			end else if (crc_wait_frame_q && frame_end) begin
				crc_wait_frame_q <= 1'b0;
				o_crc_busy <= 1'b0;
			end
		end
	end

	// Both bytes come from one stored word, so either read order gives
	// a matching pair.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			result_q <= `RESULT_RST;
		end else if (i_ce) begin
			if (i_selftest_done) begin
				result_q <= i_selftest_ok ? `SELFTEST_PASS_WORD : i_selftest_value;
			end else if (o_crc_busy && crc_wait_frame_q && frame_end) begin
				result_q <= i_crc_ok ? `CRC_PASS_WORD : i_crc_value;
			end
		end
	end

	// ****************************************************************
	// Frame capture
	// ****************************************************************

	// Capture waits for the next frame start so that only whole frames
	// are stored; there is no way back to idle except a reset.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cap_state_q <= CAP_IDLE;
			fill_cnt_q <= 11'd0;
		end else if (i_ce) begin
			unique case (cap_state_q)
				CAP_IDLE: begin
					if (wr_hit && i_req.addr == `ADDR_SNAPSHOT_PORT &&
						i_req.wdata == `CAPTURE_CMD) begin
						cap_state_q <= CAP_ARM;
					end
				end
				CAP_ARM: begin
					if (i_pix.sof) begin
						cap_state_q <= CAP_FILL;
						fill_cnt_q <= 11'd0;
					end
				end
				CAP_FILL: begin
					if (i_pix.valid) begin
						fill_cnt_q <= fill_cnt_q + 11'd1;
						if (fill_cnt_q == `CAPTURE_PIXELS - 11'd1) begin
							cap_state_q <= CAP_READY;
						end
					end
				end
				CAP_READY: begin
				end
			endcase
		end
	end

	// Captured pixels overwrite the program memory image.
	always_ff @(posedge i_clk) begin
		if (i_ce && cap_state_q == CAP_FILL && i_pix.valid) begin
			capture_mem[fill_cnt_q] <= i_pix.data;
		end
	end

	assign pixel_at_ptr = (cap_state_q == CAP_READY) ? capture_mem[ptr_q] : 8'h00;

	// One pointer serves register and burst reads; a read in the same
	// cycle from both sees the same pixel and advances it once.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ptr_q <= 11'd0;
		end else if (i_ce && cap_state_q == CAP_READY && (snap_rd || i_burst_rd)) begin
			if (ptr_q == `CAPTURE_PIXELS - 11'd1) begin
				ptr_q <= 11'd0;
			end else begin
				ptr_q <= ptr_q + 11'd1;
			end
		end
	end

	// Burst data shows the shared pointer's pixel, zero if not ready.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_burst_data <= 8'h00;
		end else if (i_ce) begin
			o_burst_data <= i_burst_rd ? pixel_at_ptr : 8'h00;
		end
	end

	// Navigation stays halted after a capture until reset; the CRC
	// halt ends with the test.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_nav_halt <= 1'b0;
			o_firmware_lost <= 1'b0;
		end else if (i_ce) begin
			o_nav_halt <= (cap_state_q != CAP_IDLE) || o_crc_busy;
			if (cap_state_q != CAP_IDLE) begin
				o_firmware_lost <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Motion clear and pin-level configuration
	// ****************************************************************

	// Any written value clears the motion counters; nothing else moves.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_motion_clear <= 1'b0;
			o_pullup_off <= 1'b0;
			o_manual_rate <= 1'b0;
			o_frame_tick <= 1'b0;
		end else if (i_ce) begin
			o_motion_clear <= wr_hit && i_req.addr == `ADDR_MOVEMENT_ZERO;
			o_pullup_off <= ext_cfg_q[`EXT_PULLUP_OFF_BIT];
			o_manual_rate <= manual_rate_select;
			o_frame_tick <= frame_end;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Upper byte reads freeze the matching lower byte, so a changing
	// exposure or period never tears across the two reads.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			exp_low_snap_q <= 8'(`EXPOSURE_RST);
			period_low_snap_q <= 8'h00;
		end else if (rd_hit) begin
			if (i_req.addr == `ADDR_EXPOSURE_HIGH) begin
				exp_low_snap_q <= exposure_q[7:0];
			end
			if (i_req.addr == `ADDR_PERIOD_HIGH) begin
				period_low_snap_q <= period_q[7:0];
			end
		end
	end

	// Read value mux; unmapped and write-only offsets read zero.
	always_comb begin
		unique case (i_req.addr)
			`ADDR_EXT_CONFIG: begin
				rd_value = ext_cfg_q;
				rd_value[`EXT_BUSY_BIT] = (busy_cnt_q != 2'd0);
			end
			`ADDR_RESULT_LOW: rd_value = result_q[7:0];
			`ADDR_RESULT_HIGH: rd_value = result_q[15:8];
			`ADDR_EXPOSURE_LOW: rd_value = exp_low_snap_q;
			`ADDR_EXPOSURE_HIGH: rd_value = exposure_q[15:8];
			`ADDR_PERIOD_LOW: rd_value = period_low_snap_q;
			`ADDR_PERIOD_HIGH: rd_value = period_q[15:8];
			`ADDR_SNAPSHOT_PORT: rd_value = pixel_at_ptr;
			`ADDR_FP_MAX_LOW: rd_value = fp_max_shadow_q[7:0];
			`ADDR_FP_MAX_HIGH: rd_value = fp_max_shadow_q[15:8];
			`ADDR_FP_MIN_LOW: rd_value = fp_min_shadow_q[7:0];
			`ADDR_FP_MIN_HIGH: rd_value = fp_min_shadow_q[15:8];
			`ADDR_EXP_MAX_LOW: rd_value = exp_max_shadow_q[7:0];
			`ADDR_EXP_MAX_HIGH: rd_value = exp_max_shadow_q[15:8];
			default: rd_value = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_data <= 8'h00;
		end else if (i_ce) begin
			o_rd_data <= rd_hit ? rd_value : 8'h00;
		end
	end

endmodule : optical_sensor_diag_capture_regs

// *** verification/optical_diag_monitor.sv ***
`timescale 1ns/1ps
`include "optical_diag_consts.svh"

// ****************************************************************
// Port checker for the diagnostic and capture registers
// ****************************************************************
module optical_diag_monitor
	import optical_diag_pkg::*;
(
	input wire logic i_clk, // System clock.
	input wire logic i_resetn, // Asynchronous reset, active low.
	input wire logic i_ce, // Clock enable.
	input wire reg_req_t i_req, // Register port request.
	input wire logic [7:0] o_rd_data, // Register read data.
	input wire logic i_burst_rd, // Burst read strobe.
	input wire logic [7:0] o_burst_data, // Burst read data.
	input wire logic o_crc_start, // CRC start pulse.
	input wire logic o_crc_busy, // CRC running.
	input wire logic o_motion_clear, // Motion clear pulse.
	input wire logic o_nav_halt, // Navigation halted.
	input wire logic o_firmware_lost // Program memory overwritten.
);
	// One clock domain, so the clock and the reset are given once.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// Decoded requests, named once so the properties stay short.
	wire logic wr_take = i_ce && i_req.wr;
	wire logic rd_snap = i_ce && i_req.rd && i_req.addr == `ADDR_SNAPSHOT_PORT;

	// Read data may only be non-zero in the cycle after a read.
	property p_rd_idle;
		!$past(i_req.rd && i_ce) |-> o_rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("Read data without a read");
	property p_burst_idle;
		!$past(i_burst_rd && i_ce) |-> o_burst_data == 8'h00;
	endproperty
	a_burst_idle: assert property (p_burst_idle) else $error("Burst data without a strobe");
	property p_snap_zero;
		rd_snap && !o_firmware_lost |=> o_rd_data == 8'h00;
	endproperty
	a_snap_zero: assert property (p_snap_zero) else $error("Pixel data before capture");
	property p_crc_start;
		wr_take && i_req.addr == `ADDR_PROG_MEM_CMD && i_req.wdata == 8'hA1 && !o_crc_busy
			|=> o_crc_start && o_crc_busy;
	endproperty
	a_crc_start: assert property (p_crc_start) else $error("CRC did not start");
	property p_crc_other;
		wr_take && i_req.addr == `ADDR_PROG_MEM_CMD && i_req.wdata != 8'hA1 |=> !o_crc_start;
	endproperty
	a_crc_other: assert property (p_crc_other) else $error("CRC started by wrong code");
	property p_motion;
		wr_take && i_req.addr == `ADDR_MOVEMENT_ZERO |=> o_motion_clear ##1 !o_motion_clear;
	endproperty
	a_motion: assert property (p_motion) else $error("Motion clear pulse wrong");
	property p_motion_cause;
		$rose(o_motion_clear) |-> $past(wr_take && i_req.addr == `ADDR_MOVEMENT_ZERO);
	endproperty
	a_motion_cause: assert property (p_motion_cause) else $error("Motion clear uncaused");
	property p_halt;
		wr_take && i_req.addr == `ADDR_SNAPSHOT_PORT && i_req.wdata == 8'h83
			|-> ##2 o_nav_halt && o_firmware_lost;
	endproperty
	a_halt: assert property (p_halt) else $error("Capture did not halt");
	property p_halt_sticky;
		o_firmware_lost |=> o_firmware_lost && o_nav_halt;
	endproperty
	a_halt_sticky: assert property (p_halt_sticky) else $error("Halt released early");
endmodule : optical_diag_monitor

bind optical_sensor_diag_capture_regs optical_diag_monitor u_optical_diag_monitor (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_req(i_req), .o_rd_data(o_rd_data),
	.i_burst_rd(i_burst_rd), .o_burst_data(o_burst_data), .o_crc_start(o_crc_start),
	.o_crc_busy(o_crc_busy), .o_motion_clear(o_motion_clear), .o_nav_halt(o_nav_halt),
	.o_firmware_lost(o_firmware_lost)
);

// *** verification/host_port_model.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Host controller model on the register port
// ****************************************************************
module host_port_model
	import optical_diag_pkg::*;
(
	input wire logic i_clk, // System clock.
	input wire logic [7:0] i_rd_data, // Read data from the block.
	output reg_req_t o_req // Register port request.
);
	// Idle from time zero so nothing is taken during reset.
	initial begin
		o_req = '0;
	end

	// One-cycle write; the block never stalls, so no wait is needed.
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge i_clk);
		o_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		o_req.wr <= 1'b0;
	endtask : reg_write

	// Read data stands only in the next cycle, so it is sampled mid-cycle there.
	task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge i_clk);
		o_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		o_req.rd <= 1'b0;
		@(negedge i_clk);
		data = i_rd_data;
	endtask : reg_read

	// Word readback: upper byte, then lower byte at the next address down, back to back.
	task automatic read_word(input logic [7:0] hi_addr, output logic [15:0] value);
		logic [7:0] hi, lo;
		reg_read(hi_addr, hi);
		reg_read(hi_addr - 8'h01, lo);
		value = {hi, lo};
	endtask : read_word
endmodule : host_port_model

// *** verification/optical_sensor_diag_capture_regs_test.sv ***
`timescale 1ns/1ps
`include "optical_diag_consts.svh"

// ****************************************************************
// Self-checking bench for the diagnostic and capture registers
// ****************************************************************
module optical_sensor_diag_capture_regs_test
	import optical_diag_pkg::*;
;
	logic i_clk, i_resetn, i_ce, burst_rd, st_done, st_ok, crc_ok, pullup_off;
	reg_req_t req;
	pix_in_t pix;
	logic [7:0] rd_data, burst_data, b;
	logic [15:0] st_value, crc_value, w, e0, e1;
	logic crc_start, crc_busy, motion_clear, nav_halt, fw_lost, manual_rate, frame_tick;
	int err_count, checked;

	// A short CRC count keeps the run brief; the frame still gates completion.
	optical_sensor_diag_capture_regs #(.CRC_CYCLES(20)) u_optical_sensor_diag_capture_regs (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_req(req), .o_rd_data(rd_data),
		.i_pix(pix), .i_burst_rd(burst_rd), .o_burst_data(burst_data),
		.i_selftest_done(st_done), .i_selftest_ok(st_ok), .i_selftest_value(st_value),
		.i_crc_value(crc_value), .i_crc_ok(crc_ok), .o_crc_start(crc_start),
		.o_crc_busy(crc_busy), .o_motion_clear(motion_clear), .o_nav_halt(nav_halt),
		.o_firmware_lost(fw_lost), .o_pullup_off(pullup_off), .o_manual_rate(manual_rate),
		.o_frame_tick(frame_tick)
	);
	host_port_model u_host_port_model (.i_clk(i_clk), .i_rd_data(rd_data), .o_req(req));

	// Free-running 20 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// Comparisons of words and of single bits.
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp);
		check_word({15'h0000, got}, {15'h0000, exp});
	endtask : check_bit
	task automatic end_sim();
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	// Bounded wait for a frame tick, or for the CRC test to finish.
	task automatic wait_for(input bit crc);
		int n;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while ((crc ? crc_busy !== 1'b0 : frame_tick !== 1'b1) && n < 40000);
		if (n >= 40000) begin
			err_count++;
			end_sim();
		end
	endtask : wait_for
	// One automatic step is a sixteenth of the value, at least one, capped at the bound.
	function automatic logic [15:0] step_exp(input logic [15:0] e, input bit up);
		logic [15:0] s;
		s = (e >> 4) == 16'h0000 ? 16'h0001 : e >> 4;
		if (up) begin
			return (e + s > `EXP_MAX_RST) ? `EXP_MAX_RST : e + s;
		end
		return e - s;
	endfunction : step_exp
	function automatic logic [7:0] pixel_of(input int i);
		return 8'(i * 7 + 3);
	endfunction : pixel_of

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic reset_values();
		u_host_port_model.reg_write(`ADDR_EXPOSURE_HIGH, 8'h55);
		u_host_port_model.read_word(`ADDR_EXPOSURE_HIGH, w);
		check_word(w, 16'h0085);
		u_host_port_model.read_word(`ADDR_PERIOD_HIGH, w);
		check_word(w, 16'h6590);
		u_host_port_model.read_word(`ADDR_RESULT_HIGH, w);
		check_word(w, 16'h0000);
		u_host_port_model.reg_read(`ADDR_SNAPSHOT_PORT, b);
		check_word({8'h00, b}, 16'h0000);
		u_host_port_model.reg_read(8'h30, b);
		check_word({8'h00, b}, 16'h0000);
	endtask : reset_values
	task automatic self_test();
		@(posedge i_clk);
		st_ok <= 1'b1;
		st_done <= 1'b1;
		@(posedge i_clk);
		st_done <= 1'b0;
		u_host_port_model.reg_read(`ADDR_RESULT_LOW, b);
		check_word({8'h00, b}, 16'h00D5);
		u_host_port_model.reg_read(`ADDR_RESULT_HIGH, b);
		check_word({8'h00, b}, 16'h00A9);
		@(posedge i_clk);
		st_ok <= 1'b0;
		st_value <= 16'h1234;
		st_done <= 1'b1;
		@(posedge i_clk);
		st_done <= 1'b0;
		u_host_port_model.read_word(`ADDR_RESULT_HIGH, w);
		check_word(w, 16'h1234);
		u_host_port_model.reg_write(`ADDR_MOVEMENT_ZERO, 8'h5C);
		@(negedge i_clk);
		check_bit(motion_clear, 1'b1);
	endtask : self_test
	task automatic exposure_loop();
		@(posedge i_clk);
		pix.avg <= 8'h20;
		wait_for(1'b0);
		u_host_port_model.read_word(`ADDR_EXPOSURE_HIGH, e0);
		wait_for(1'b0);
		u_host_port_model.read_word(`ADDR_EXPOSURE_HIGH, e1);
		check_word(e1, step_exp(e0, 1'b1));
		@(posedge i_clk);
		pix.avg <= 8'h80;
		pix.peak <= 8'hF8;
		wait_for(1'b0);
		u_host_port_model.read_word(`ADDR_EXPOSURE_HIGH, e0);
		check_word(e0, step_exp(e1, 1'b0));
		@(posedge i_clk);
		pix.peak <= 8'h80;
		u_host_port_model.reg_write(`ADDR_PROG_MEM_CMD, 8'h55);
		u_host_port_model.reg_write(`ADDR_PROG_MEM_CMD, 8'hA1);
		@(negedge i_clk);
		check_bit(crc_start, 1'b1);
		check_bit(crc_busy, 1'b1);
		wait_for(1'b1);
		u_host_port_model.read_word(`ADDR_RESULT_HIGH, w);
		check_word(w, 16'hBEEF);
		u_host_port_model.reg_write(`ADDR_EXT_CONFIG, 8'h07);
		u_host_port_model.reg_write(`ADDR_FP_MAX_LOW, 8'hA8);
		u_host_port_model.reg_write(`ADDR_FP_MAX_HIGH, 8'h61);
		u_host_port_model.reg_read(`ADDR_EXT_CONFIG, b);
		check_word({8'h00, b}, 16'h008F);
		wait_for(1'b0);
		check_bit(manual_rate & pullup_off, 1'b1);
		u_host_port_model.read_word(`ADDR_EXPOSURE_HIGH, w);
		check_word(w, `EXP_MAX_RST);
		u_host_port_model.read_word(`ADDR_PERIOD_HIGH, w);
		check_word(w, 16'h61A8);
	endtask : exposure_loop
	task automatic capture();
		u_host_port_model.reg_write(`ADDR_SNAPSHOT_PORT, 8'h83);
		u_host_port_model.reg_read(`ADDR_SNAPSHOT_PORT, b);
		check_word({8'h00, b}, 16'h0000);
		check_bit(nav_halt & fw_lost, 1'b1);
		@(posedge i_clk);
		pix.sof <= 1'b1;
		@(posedge i_clk);
		pix.sof <= 1'b0;
		for (int i = 0; i < 1536; i++) begin
			pix.valid <= 1'b1;
			pix.data <= pixel_of(i);
			@(posedge i_clk);
		end
		pix.valid <= 1'b0;
		u_host_port_model.reg_read(`ADDR_SNAPSHOT_PORT, b);
		check_word({8'h00, b}, {8'h00, pixel_of(0)});
		u_host_port_model.reg_write(`ADDR_SNAPSHOT_PORT, 8'h11);
		u_host_port_model.reg_read(`ADDR_SNAPSHOT_PORT, b);
		check_word({8'h00, b}, {8'h00, pixel_of(1)});
		@(posedge i_clk);
		burst_rd <= 1'b1;
		@(posedge i_clk);
		burst_rd <= 1'b0;
		@(negedge i_clk);
		check_word({8'h00, burst_data}, {8'h00, pixel_of(2)});
		for (int i = 3; i <= 1536; i++) begin
			u_host_port_model.reg_read(`ADDR_SNAPSHOT_PORT, b);
			check_word({8'h00, b}, {8'h00, pixel_of(i % 1536)});
		end
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(negedge i_clk);
		check_bit(nav_halt | fw_lost, 1'b0);
	endtask : capture
	// Reset, then the scenarios in an order that leaves the lasting halt to the end.
	initial begin
		{i_resetn, burst_rd, st_done, st_ok, st_value, crc_value} = '0;
		i_ce = 1'b1;
		crc_ok = 1'b1;
		pix = '{sof: 1'b0, valid: 1'b0, data: 8'h00, avg: 8'h80, peak: 8'h80};
		err_count = 0;
		checked = 0;
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'b1;
		reset_values();
		self_test();
		exposure_loop();
		capture();
		end_sim();
	end
endmodule : optical_sensor_diag_capture_regs_test
